// *** inc/ata_tf_pkg.sv ***
package ata_tf_pkg;

  // Map configurations.
  localparam logic [1:0] MODE_MEM = 2'h0;
  localparam logic [1:0] MODE_CONTIG = 2'h1;
  localparam logic [1:0] MODE_PRIMARY = 2'h2;
  localparam logic [1:0] MODE_SECONDARY = 2'h3;

  // Upper address fields A9-A4 of the legacy maps.
  localparam logic [5:0] PRI_TASK_BASE = 6'h1F;
  localparam logic [5:0] PRI_CTL_BASE = 6'h3F;
  localparam logic [5:0] SEC_TASK_BASE = 6'h17;
  localparam logic [5:0] SEC_CTL_BASE = 6'h37;

  // Address bit that opens the memory data window.
  localparam int MEM_WIN_BIT = 10;

  // Register offsets.
  localparam logic [3:0] OFF_SECTOR_DATA_PORT = 4'h0;
  localparam logic [3:0] OFF_ERROR_OR_FEATURE = 4'h1;
  localparam logic [3:0] OFF_TRANSFER_SECTOR_COUNT = 4'h2;
  localparam logic [3:0] OFF_START_SECTOR_NUMBER = 4'h3;
  localparam logic [3:0] OFF_CYLINDER_LOW_BYTE = 4'h4;
  localparam logic [3:0] OFF_CYLINDER_HIGH_BYTE = 4'h5;
  localparam logic [3:0] OFF_DRIVE_HEAD_SELECT = 4'h6;
  localparam logic [3:0] OFF_STATE_OR_OPCODE = 4'h7;
  localparam logic [3:0] OFF_DUP_EVEN_DATA = 4'h8;
  localparam logic [3:0] OFF_DUP_ODD_DATA = 4'h9;
  localparam logic [3:0] OFF_UNDEF_A = 4'hA;
  localparam logic [3:0] OFF_UNDEF_B = 4'hB;
  localparam logic [3:0] OFF_UNDEF_C = 4'hC;
  localparam logic [3:0] OFF_DUP_ERROR_OR_FEATURE = 4'hD;
  localparam logic [3:0] OFF_SHADOW_STATE_OR_CTL = 4'hE;
  localparam logic [3:0] OFF_DRIVE_ADDR_READBACK = 4'hF;

  // Values after reset and for reads of undefined offsets.
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] UNDEF_READ_VALUE = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_HOLD = 3'b100
  } cycle_state_t;

  typedef enum logic [2:0] {
    ACC_WORD_DATA,
    ACC_BYTE_NEXT,
    ACC_BYTE_ODD,
    ACC_TASK,
    ACC_UNDEF
  } acc_kind_t;

endpackage

// *** src/ata_task_file_address_decoder.sv ***
`timescale 1ns/1ps
module ata_task_file_address_decoder (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Configuration
  input wire logic [1:0] map_mode,
  // Card bus control
  input wire logic reg_n,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic iord_n,
  input wire logic iowr_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [10:0] addr,
  // Card data bus
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_lo,
  output logic data_oe_hi,
  output logic iois16_n,
  // Task file register port
  output logic [3:0] tf_offset,
  output logic tf_rd,
  output logic tf_wr,
  output logic [7:0] tf_wdata,
  input wire logic [7:0] tf_rdata,
  // Data buffer port
  output logic buf_pop,
  output logic buf_push,
  output logic [15:0] buf_wdata,
  input wire logic [15:0] buf_rdata
);

  ata_tf_pkg::cycle_state_t state_q;
  ata_tf_pkg::cycle_state_t state_d;
  ata_tf_pkg::acc_kind_t kind;

  logic dec_hit;
  logic dec_io;
  logic [3:0] dec_off;

  logic rd_act;
  logic wr_act;
  logic lane_word;
  logic lane_hi;
  logic lane_any;
  logic start;
  logic [3:0] reg_off;
  logic out_hi;
  logic [7:0] wbyte;

  // Partial-word holding register shared by the byte paths.
  logic held_q;
  logic held_d;
  logic held_wr_q;
  logic held_wr_d;
  logic even_done_q;
  logic even_done_d;
  logic odd_done_q;
  logic odd_done_d;
  logic [15:0] held_word_q;
  logic [15:0] held_word_d;
  logic fresh;
  logic sel_odd;
  logic [15:0] word_src;
  logic [7:0] rbyte;

  logic [15:0] data_out_q;
  logic [15:0] data_out_d;
  logic oe_lo_q;
  logic oe_lo_d;
  logic oe_hi_q;
  logic oe_hi_d;
  logic iois16_n_q;
  logic out_hi_q;
  logic [3:0] tf_offset_q;
  logic tf_rd_q;
  logic tf_wr_q;
  logic [7:0] tf_wdata_q;
  logic buf_pop_q;
  logic buf_pop_d;
  logic buf_push_q;
  logic buf_push_d;
  logic [15:0] buf_wdata_q;
  logic [15:0] buf_wdata_d;

  card_addr_map u_map (
    .map_mode(map_mode),
    .reg_n(reg_n),
    .addr(addr),
    .hit(dec_hit),
    .io_space(dec_io),
    .offset(dec_off)
  );

  always_comb begin
    rd_act = (map_mode == ata_tf_pkg::MODE_MEM) ? ~oe_n : ~iord_n;
    wr_act = (map_mode == ata_tf_pkg::MODE_MEM) ? ~we_n : ~iowr_n;
    lane_word = ~ce1_n & ~ce2_n;
    lane_hi = ce1_n & ~ce2_n;
    lane_any = ~ce1_n | ~ce2_n;
    start = (state_q == ata_tf_pkg::ST_IDLE) && dec_hit && lane_any && (rd_act ^ wr_act);
    // A high-lane-only byte reaches the odd register of the even/odd pair.
    reg_off = lane_hi ? (dec_off | 4'h1) : dec_off;
    out_hi = lane_hi | (lane_word & reg_off[0]);
    wbyte = out_hi ? data_in[15:8] : data_in[7:0];
    if (lane_word && (dec_off[3:1] == 3'h0 || dec_off[3:1] == 3'h4)) begin
      kind = ata_tf_pkg::ACC_WORD_DATA;
    end else begin
      case (reg_off)
        ata_tf_pkg::OFF_SECTOR_DATA_PORT, ata_tf_pkg::OFF_DUP_EVEN_DATA: kind = ata_tf_pkg::ACC_BYTE_NEXT;
        ata_tf_pkg::OFF_DUP_ODD_DATA: kind = ata_tf_pkg::ACC_BYTE_ODD;
        ata_tf_pkg::OFF_UNDEF_A, ata_tf_pkg::OFF_UNDEF_B, ata_tf_pkg::OFF_UNDEF_C: kind = ata_tf_pkg::ACC_UNDEF;
        default: kind = ata_tf_pkg::ACC_TASK;
      endcase
    end
  end

  // Byte pairing: a word is fetched or assembled on the first byte, released once both halves moved.
  always_comb begin
    fresh = ~held_q | (held_wr_q != wr_act);
    sel_odd = (kind == ata_tf_pkg::ACC_BYTE_ODD) || (!fresh && even_done_q);
    word_src = fresh ? buf_rdata : held_word_q;
    rbyte = sel_odd ? word_src[15:8] : word_src[7:0];
    held_d = held_q;
    held_wr_d = held_wr_q;
    even_done_d = even_done_q;
    odd_done_d = odd_done_q;
    held_word_d = held_word_q;
    buf_pop_d = 1'b0;
    buf_push_d = 1'b0;
    buf_wdata_d = buf_wdata_q;
    if (start) begin
      case (kind)
        ata_tf_pkg::ACC_WORD_DATA: begin
          // A word access abandons any half-moved word.
          held_d = 1'b0;
          even_done_d = 1'b0;
          odd_done_d = 1'b0;
          buf_pop_d = rd_act;
          buf_push_d = wr_act;
          buf_wdata_d = data_in;
        end
        ata_tf_pkg::ACC_BYTE_NEXT, ata_tf_pkg::ACC_BYTE_ODD: begin
          // Odd-only repeats are the host's concern; a second odd byte just moves to a new word.
          if (fresh || (sel_odd ? odd_done_q : even_done_q)) begin
            held_word_d = rd_act ? buf_rdata : ata_tf_pkg::RST_WORD;
            buf_pop_d = rd_act;
            even_done_d = ~sel_odd;
            odd_done_d = sel_odd;
          end else begin
            even_done_d = even_done_q | ~sel_odd;
            odd_done_d = odd_done_q | sel_odd;
          end
          if (wr_act) begin
            if (sel_odd) begin
              held_word_d[15:8] = wbyte;
            end else begin
              held_word_d[7:0] = wbyte;
            end
          end
          held_wr_d = wr_act;
          held_d = 1'b1;
          if (even_done_d && odd_done_d) begin
            held_d = 1'b0;
            even_done_d = 1'b0;
            odd_done_d = 1'b0;
            buf_push_d = wr_act;
            buf_wdata_d = held_word_d;
          end
        end
        default: begin
          held_d = held_q;
        end
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ata_tf_pkg::ST_IDLE: begin
        if (start) begin
          state_d = (rd_act && kind == ata_tf_pkg::ACC_TASK) ? ata_tf_pkg::ST_FETCH : ata_tf_pkg::ST_HOLD;
        end
      end
      ata_tf_pkg::ST_FETCH: state_d = ata_tf_pkg::ST_HOLD;
      ata_tf_pkg::ST_HOLD: begin
        if ((!rd_act && !wr_act) || !lane_any) begin
          state_d = ata_tf_pkg::ST_IDLE;
        end
      end
      default: state_d = ata_tf_pkg::ST_IDLE;
    endcase
  end

  // Read data and lane enables for the access being served.
  always_comb begin
    data_out_d = data_out_q;
    oe_lo_d = oe_lo_q;
    oe_hi_d = oe_hi_q;
    if (start && rd_act) begin
      oe_lo_d = lane_word | ~lane_hi;
      oe_hi_d = lane_word | lane_hi;
      case (kind)
        ata_tf_pkg::ACC_WORD_DATA: data_out_d = buf_rdata;
        ata_tf_pkg::ACC_BYTE_NEXT, ata_tf_pkg::ACC_BYTE_ODD: data_out_d = out_hi ? {rbyte, 8'h00} : {8'h00, rbyte};
        ata_tf_pkg::ACC_UNDEF: data_out_d = {ata_tf_pkg::UNDEF_READ_VALUE, ata_tf_pkg::UNDEF_READ_VALUE};
        default: data_out_d = ata_tf_pkg::RST_WORD;
      endcase
    end else if (state_q == ata_tf_pkg::ST_FETCH) begin
      data_out_d = out_hi_q ? {tf_rdata, 8'h00} : {8'h00, tf_rdata};
    end else if (state_d == ata_tf_pkg::ST_IDLE) begin
      oe_lo_d = 1'b0;
      oe_hi_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ata_tf_pkg::ST_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= 1'b0;
      held_wr_q <= 1'b0;
      even_done_q <= 1'b0;
      odd_done_q <= 1'b0;
      held_word_q <= ata_tf_pkg::RST_WORD;
    end else if (clk_en) begin
      held_q <= held_d;
      held_wr_q <= held_wr_d;
      even_done_q <= even_done_d;
      odd_done_q <= odd_done_d;
      held_word_q <= held_word_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buf_pop_q <= 1'b0;
      buf_push_q <= 1'b0;
      buf_wdata_q <= ata_tf_pkg::RST_WORD;
    end else if (clk_en) begin
      buf_pop_q <= buf_pop_d;
      buf_push_q <= buf_push_d;
      buf_wdata_q <= buf_wdata_d;
    end
  end

  // Task file strobes; the duplicate error/feature port maps onto the primary one.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tf_offset_q <= ata_tf_pkg::OFF_SECTOR_DATA_PORT;
      tf_rd_q <= 1'b0;
      tf_wr_q <= 1'b0;
      tf_wdata_q <= 8'h00;
      out_hi_q <= 1'b0;
    end else if (clk_en) begin
      tf_rd_q <= start && rd_act && kind == ata_tf_pkg::ACC_TASK;
      tf_wr_q <= start && wr_act && kind == ata_tf_pkg::ACC_TASK;
      if (start) begin
        tf_offset_q <= (reg_off == ata_tf_pkg::OFF_DUP_ERROR_OR_FEATURE) ?
          ata_tf_pkg::OFF_ERROR_OR_FEATURE : reg_off;
        tf_wdata_q <= wbyte;
        out_hi_q <= out_hi;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_q <= ata_tf_pkg::RST_WORD;
      oe_lo_q <= 1'b0;
      oe_hi_q <= 1'b0;
    end else if (clk_en) begin
      data_out_q <= data_out_d;
      oe_lo_q <= oe_lo_d;
      oe_hi_q <= oe_hi_d;
    end
  end

  // Every port the card answers in an I/O map accepts 8 and 16 bit cycles alike.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      iois16_n_q <= 1'b1;
    end else if (clk_en) begin
      iois16_n_q <= ~(dec_hit & dec_io & lane_any);
    end
  end

  assign data_out = data_out_q;
  assign data_oe_lo = oe_lo_q;
  assign data_oe_hi = oe_hi_q;
  assign iois16_n = iois16_n_q;
  assign tf_offset = tf_offset_q;
  assign tf_rd = tf_rd_q;
  assign tf_wr = tf_wr_q;
  assign tf_wdata = tf_wdata_q;
  assign buf_pop = buf_pop_q;
  assign buf_push = buf_push_q;
  assign buf_wdata = buf_wdata_q;

endmodule

// *** src/card_addr_map.sv ***
`timescale 1ns/1ps
module card_addr_map (
  // Configuration
  input wire logic [1:0] map_mode,
  // Card address
  input wire logic reg_n,
  input wire logic [10:0] addr,
  // Decode result
  output logic hit,
  output logic io_space,
  output logic [3:0] offset
);

  always_comb begin
    hit = 1'b0;
    io_space = 1'b0;
    offset = addr[3:0];
    case (map_mode)
      ata_tf_pkg::MODE_MEM: begin
        hit = reg_n;
        if (addr[ata_tf_pkg::MEM_WIN_BIT]) begin
          // The whole window folds onto the two duplicate data ports.
          offset = addr[0] ? ata_tf_pkg::OFF_DUP_ODD_DATA : ata_tf_pkg::OFF_DUP_EVEN_DATA;
        end else begin
          offset = addr[3:0];
        end
      end
      ata_tf_pkg::MODE_CONTIG: begin
        hit = ~reg_n;
        io_space = 1'b1;
        offset = addr[3:0];
      end
      ata_tf_pkg::MODE_PRIMARY, ata_tf_pkg::MODE_SECONDARY: begin
        io_space = 1'b1;
        if (addr[9:4] == ((map_mode == ata_tf_pkg::MODE_PRIMARY) ?
            ata_tf_pkg::PRI_TASK_BASE : ata_tf_pkg::SEC_TASK_BASE) && !addr[3]) begin
          hit = ~reg_n;
          offset = {1'b0, addr[2:0]};
        end else if (addr[9:4] == ((map_mode == ata_tf_pkg::MODE_PRIMARY) ?
            ata_tf_pkg::PRI_CTL_BASE : ata_tf_pkg::SEC_CTL_BASE) && addr[3:1] == 3'h3) begin
          hit = ~reg_n;
          offset = addr[0] ? ata_tf_pkg::OFF_DRIVE_ADDR_READBACK : ata_tf_pkg::OFF_SHADOW_STATE_OR_CTL;
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

endmodule

// *** tb/ata_task_file_address_decoder_test.sv ***
`timescale 1ns/1ps
module ata_task_file_address_decoder_test;
  logic mclk, rst_n, clk_en, reg_n, ce1_n, ce2_n, iord_n, iowr_n, oe_n, we_n;
  logic data_oe_lo, data_oe_hi, iois16_n, tf_rd, tf_wr, buf_pop, buf_push, oe_seen, io_seen;
  logic [1:0] map_mode;
  logic [10:0] addr;
  logic [15:0] data_in, data_out, buf_wdata, buf_rdata, q;
  logic [3:0] tf_offset, a1, a2;
  logic [7:0] tf_wdata, tf_rdata, k;
  logic [23:0] pairs;
  int mismatches, checks_done, cyc, i;
  ata_task_file_address_decoder dut_u (.mclk, .rst_n, .clk_en, .map_mode, .reg_n, .ce1_n, .ce2_n, .iord_n,
    .iowr_n, .oe_n, .we_n, .addr, .data_in, .data_out, .data_oe_lo, .data_oe_hi, .iois16_n, .tf_offset,
    .tf_rd, .tf_wr, .tf_wdata, .tf_rdata, .buf_pop, .buf_push, .buf_wdata, .buf_rdata);
  tf_backend_model pm_u (.mclk, .rst_n, .tf_offset, .tf_wr, .tf_wdata, .tf_rdata, .buf_pop, .buf_push,
    .buf_wdata, .buf_rdata);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One whole card cycle; strobes then stay high a full cycle before the next one.
  task automatic acc(input logic c1, input logic c2, input logic w, input logic [10:0] a, input logic [15:0] d);
    @(negedge mclk);
    {ce1_n, ce2_n, addr, data_in} = {c1, c2, a, d};
    if (map_mode == ata_tf_pkg::MODE_MEM) {oe_n, we_n} = {w, !w};
    else {iord_n, iowr_n} = {w, !w};
    repeat (2) @(negedge mclk);
    {q, oe_seen, io_seen} = {data_out, data_oe_lo | data_oe_hi, iois16_n};
    {iord_n, iowr_n, oe_n, we_n, ce1_n, ce2_n} = 6'h3F;
  endtask
  task automatic setm(input logic [1:0] m);
    @(negedge mclk);
    map_mode = m;
    reg_n = (m == ata_tf_pkg::MODE_MEM);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    {clk_en, reg_n, ce1_n, ce2_n, iord_n, iowr_n, oe_n, we_n} = 8'hBF;
    {rst_n, map_mode, addr, data_in, k, pairs} = {1'b0, 2'h1, 11'h000, 16'h0000, 8'h00, 24'h008998};
    repeat (3) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    chk(data_out, 16'h0000);
    chk({15'h0000, iois16_n}, 16'h0001);
    for (i = 0; i < 3; i++) begin
      acc(0, 0, 0, {7'h55, (i == 0) ? 4'h0 : 4'(7 + i)}, 16'h0000);
      chk(q, {~k, k});
      chk({15'h0000, io_seen}, 16'h0000);
      k++;
    end
    for (i = 0; i < 3; i++) begin
      a1 = pairs[8 * (2 - i) + 4 +: 4];
      a2 = pairs[8 * (2 - i) +: 4];
      acc(0, 1, 0, {7'h00, a1}, 16'h0000);
      chk(q, {8'h00, (i == 2) ? ~k : k});
      acc(0, 1, 0, {7'h00, a2}, 16'h0000);
      chk(q, {8'h00, (i == 2) ? k : ~k});
      k++;
    end
    acc(1, 0, 1, 11'h000, 16'h3C00);
    acc(0, 1, 0, 11'h00D, 16'h0000);
    chk(q[7:0], 8'h3C);
    acc(1, 0, 0, 11'h000, 16'h0000);
    chk(q[15:8], 8'h3C);
    for (i = 2; i < 15; i++) begin
      if (i < 8 || i == 14) begin
        acc(0, 1, 1, {7'h2A, 4'(i)}, {8'h00, 8'(8'h40 + i)});
        acc(0, 1, 0, {7'h2A, 4'(i)}, 16'h0000);
        chk(q[7:0], 8'(8'h40 + i));
      end
    end
    for (i = 10; i < 13; i++) begin
      acc(0, 1, 1, 11'(i), 16'h00FF);
      acc(0, 1, 0, 11'(i), 16'h0000);
      chk(q, 16'h0000);
    end
    acc(0, 0, 0, 11'h000, 16'h0000);
    chk(q, {~k, k});
    k++;
    acc(0, 0, 1, 11'h000, 16'h1234);
    chk(pm_u.push_q, 16'h1234);
    acc(0, 1, 1, 11'h008, 16'h0056);
    acc(0, 1, 1, 11'h009, 16'h0078);
    chk(pm_u.push_q, 16'h7856);
    // A frozen block must not answer a cycle that starts and ends while the enable is low.
    clk_en = 1'b0;
    acc(0, 0, 0, 11'h000, 16'h0000);
    chk({15'h0000, oe_seen}, 16'h0000);
    clk_en = 1'b1;
    reg_n = 1'b1;
    acc(0, 0, 0, 11'h000, 16'h0000);
    chk({15'h0000, oe_seen}, 16'h0000);
    setm(ata_tf_pkg::MODE_PRIMARY);
    acc(0, 1, 0, 11'h1F7, 16'h0000);
    chk(q[7:0], 8'h47);
    acc(0, 1, 0, 11'h3F6, 16'h0000);
    chk(q[7:0], 8'h4E);
    acc(0, 1, 0, 11'h2F7, 16'h0000);
    chk({15'h0000, oe_seen}, 16'h0000);
    setm(ata_tf_pkg::MODE_SECONDARY);
    acc(0, 1, 0, 11'h577, 16'h0000);
    chk(q[7:0], 8'h47);
    acc(0, 1, 0, 11'h376, 16'h0000);
    chk(q[7:0], 8'h4E);
    setm(ata_tf_pkg::MODE_MEM);
    acc(0, 0, 0, 11'h400, 16'h0000);
    chk(q, {~k, k});
    k++;
    acc(0, 0, 0, 11'h6AA, 16'h0000);
    chk(q, {~k, k});
    k++;
    acc(0, 1, 0, 11'h7FE, 16'h0000);
    chk(q[7:0], k);
    acc(0, 1, 0, 11'h401, 16'h0000);
    chk(q, {8'h00, ~k});
    acc(0, 1, 0, 11'h3F2, 16'h0000);
    chk(q[7:0], 8'h42);
    reg_n = 1'b0;
    acc(0, 0, 0, 11'h400, 16'h0000);
    chk({15'h0000, oe_seen}, 16'h0000);
    wrap_up();
  end
endmodule
bind ata_task_file_address_decoder ata_tf_chk chk_u (.mclk, .rst_n, .clk_en, .map_mode, .reg_n, .ce1_n, .ce2_n,
  .iord_n, .iowr_n, .oe_n, .we_n, .data_in, .data_oe_lo, .iois16_n, .tf_offset, .tf_rd, .tf_wr, .tf_wdata,
  .buf_pop, .buf_push, .buf_wdata);

// *** tb/ata_tf_chk.sv ***
`timescale 1ns/1ps
module ata_tf_chk (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Configuration and card bus
  input wire logic [1:0] map_mode,
  input wire logic reg_n,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic iord_n,
  input wire logic iowr_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] data_in,
  input wire logic data_oe_lo,
  input wire logic iois16_n,
  // Back end
  input wire logic [3:0] tf_offset,
  input wire logic tf_rd,
  input wire logic tf_wr,
  input wire logic [7:0] tf_wdata,
  input wire logic buf_pop,
  input wire logic buf_push,
  input wire logic [15:0] buf_wdata
);
  logic [15:0] din_q;
  logic word_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      din_q <= 16'h0000;
      word_q <= 1'b0;
    end else begin
      din_q <= data_in;
      word_q <= !ce1_n && !ce2_n;
    end
  end
  a_wr_pulse: assert property (tf_wr |=> !tf_wr) else $error("task write pulse too long");
  a_pop_pulse: assert property (buf_pop |=> !buf_pop) else $error("pop pulse too long");
  a_rd_cause: assert property (tf_rd |-> !$past(iord_n) || !$past(oe_n)) else $error("task read without strobe");
  a_pop_cause: assert property (buf_pop |-> !$past(iord_n) || !$past(oe_n)) else $error("pop without read");
  a_push_cause: assert property (buf_push |-> !$past(iowr_n) || !$past(we_n)) else $error("push without write");
  a_wr_data: assert property (tf_wr |-> (tf_wdata == din_q[7:0] || tf_wdata == din_q[15:8]))
    else $error("task write data not from bus");
  a_undef_quiet: assert property ((tf_wr || tf_rd) |-> !(tf_offset inside {4'hA, 4'hB, 4'hC}))
    else $error("undefined offset reached");
  a_oe_cause: assert property (data_oe_lo |-> !$past(iord_n) || !$past(oe_n) || !$past(iord_n, 2) || !$past(oe_n, 2))
    else $error("bus driven without read");
  a_io_wide: assert property ((clk_en && !reg_n && map_mode == ata_tf_pkg::MODE_CONTIG && !(iord_n && iowr_n)
    && !(ce1_n && ce2_n)) |=> !iois16_n) else $error("no 16-bit signal");
  a_word_push: assert property ((buf_push && word_q) |-> buf_wdata == din_q) else $error("word push data");
endmodule

// *** tb/tf_backend_model.sv ***
`timescale 1ns/1ps
module tf_backend_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Task file side
  input wire logic [3:0] tf_offset,
  input wire logic tf_wr,
  input wire logic [7:0] tf_wdata,
  output logic [7:0] tf_rdata,
  // Buffer side
  input wire logic buf_pop,
  input wire logic buf_push,
  input wire logic [15:0] buf_wdata,
  output logic [15:0] buf_rdata
);
  logic [7:0] regs_q [16];
  logic [7:0] head_q;
  logic [15:0] push_q;
  assign tf_rdata = regs_q[tf_offset];
  assign buf_rdata = {~head_q, head_q};
  // The head moves only on a pop, so no host address can reach into the buffer.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      head_q <= 8'h00;
      push_q <= 16'h0000;
    end else begin
      if (buf_pop) head_q <= head_q + 8'h01;
      if (buf_push) push_q <= buf_wdata;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int j = 0; j < 16; j++) regs_q[j] <= 8'h00;
    end else if (tf_wr) begin
      regs_q[tf_offset] <= tf_wdata;
    end
  end
endmodule
